/* dsp_param_indirect_access.sv */
`timescale 1ns/1ps
module dsp_param_indirect_access
  import dsp_param_pkg::*;
(
  input  logic                   i_clk,
  input  logic                   i_sys_rst,
  input  logic                   i_ce,
  input  logic                   i_conduit_wr,
  input  logic                   i_conduit_rd,
  input  logic [1:0]             i_conduit_sel,
  input  logic [BYTE_W-1:0]      i_conduit_wdata,
  input  logic                   i_dsp_data_avail,
  input  logic                   i_tone_detected,
  input  logic [TONE_TYPE_W-1:0] i_tone_type,
  input  logic [DATA_W-1:0]      i_carrier_level,
  input  logic [DATA_W-1:0]      i_answer_level,
  output logic [BYTE_W-1:0]      o_conduit_rdata,
  output logic                   o_conduit_rvalid,
  output logic                   o_dsp_wr,
  output logic [ADDR_W-1:0]      o_dsp_addr,
  output logic [DATA_W-1:0]      o_dsp_data,
  output logic                   o_coef_wr,
  output logic                   o_squaring_en,
  output logic                   o_cascade_dis,
  output logic [REPORT_W-1:0]    o_report_en,
  output logic [TG_DIGIT_W-1:0]  o_dtmf_digit,
  output logic [TG_TYPE_W-1:0]   o_tone_type,
  output logic                   o_carrier_valid,
  output logic                   o_answer_valid,
  output logic [DATA_W-1:0]      o_dsp_xmit_full_scale_level,
  output logic [DATA_W-1:0]      o_dtmf_high_tone_level,
  output logic [DATA_W-1:0]      o_dtmf_twist_ratio,
  output logic [DATA_W-1:0]      o_user_tone_frequency,
  output logic [DATA_W-1:0]      o_call_progress_detect_level,
  output logic [DATA_W-1:0]      o_user_freq_detector_1,
  output logic [DATA_W-1:0]      o_user_freq_detector_2,
  output logic [DATA_W-1:0]      o_user_freq_detector_3,
  output logic [DATA_W-1:0]      o_user_freq_detector_4,
  output logic [DATA_W-1:0]      o_tone_generation_level,
  output logic [DATA_W-1:0]      o_user_detector_sensitivity,
  output logic [DATA_W-1:0]      o_carrier_on_level,
  output logic [DATA_W-1:0]      o_carrier_off_level,
  output logic [DATA_W-1:0]      o_answer_on_level,
  output logic [DATA_W-1:0]      o_answer_off_level
);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  logic [BYTE_W-1:0]     fsel_q;
  logic [BYTE_W-1:0]     fsel_d;
  logic [ADDR_W-1:0]     addr_q;
  logic [ADDR_W-1:0]     addr_d;
  logic [DATA_HI_W-1:0]  data_hi_q;
  logic [DATA_HI_W-1:0]  data_hi_d;
  logic                  dsp_wr_q;
  logic [ADDR_W-1:0]     dsp_addr_q;
  logic [DATA_W-1:0]     dsp_data_q;
  logic                  coef_wr_q;
  logic                  avail_q;
  logic                  avail_d;
  logic [BYTE_W-1:0]     rdata_q;
  logic [BYTE_W-1:0]     rdata_d;
  logic                  rvalid_q;
  logic                  squaring_q;
  logic                  cascade_q;
  logic [REPORT_W-1:0]   report_q;
  logic [TG_DIGIT_W-1:0] digit_q;
  logic [TG_TYPE_W-1:0]  ttype_q;
  logic                  carrier_q;
  logic                  carrier_d;
  logic                  answer_q;
  logic                  answer_d;
  logic [DATA_W-1:0]     param_q [NUM_PARAMS];

  wire sel_low  = (i_conduit_sel == CONDUIT_LOW);
  wire sel_high = (i_conduit_sel == CONDUIT_HIGH);
  wire sel_fsel = (i_conduit_sel == CONDUIT_FSEL);
  wire mode_addr = (fsel_q == FSEL_ADDR);
  wire mode_data = (fsel_q == FSEL_DATA);
  wire mode_ctrl = (fsel_q == FSEL_CTRL);

  // R1: selector decode of writes
  wire wr_fsel      = i_conduit_wr && sel_fsel;
  wire wr_addr_low  = i_conduit_wr && sel_low && mode_addr;
  wire wr_addr_high = i_conduit_wr && sel_high && mode_addr;
  wire wr_data_low  = i_conduit_wr && sel_low && mode_data;
  wire wr_data_high = i_conduit_wr && sel_high && mode_data;
  wire wr_ctrl_low  = i_conduit_wr && sel_low && mode_ctrl;
  wire wr_ctrl_high = i_conduit_wr && sel_high && mode_ctrl;

  // R1: selector decode of reads
  wire rd_status = i_conduit_rd && sel_low && mode_ctrl;
  wire rd_fsel   = i_conduit_rd && sel_fsel;

  assign fsel_d = wr_fsel ? i_conduit_wdata : fsel_q;

  // R5: address bytes captured
  assign addr_d = wr_addr_low  ? {addr_q[ADDR_W-1:BYTE_W], i_conduit_wdata} :
                  wr_addr_high ? {i_conduit_wdata, addr_q[BYTE_W-1:0]} : addr_q;

  // R7: upper six data bits
  assign data_hi_d = wr_data_high ? i_conduit_wdata[DATA_HI_W-1:0] : data_hi_q;

  // R6: low byte completes word
  wire [DATA_W-1:0] commit_data = {data_hi_q, i_conduit_wdata};
  wire              commit      = wr_data_low;

  // R19: coefficient range detect
  wire addr_is_coef = (addr_q >= COEF_FIRST) && (addr_q <= COEF_LAST);

  // R9: sticky available flag, set wins
  assign avail_d = i_dsp_data_avail ? 1'b1 : (rd_status ? 1'b0 : avail_q);

  // R9: status byte layout
  wire [BYTE_W-1:0] status_byte = {avail_q, i_tone_detected, 1'b0, i_tone_type};

  assign rdata_d = rd_status ? status_byte :
                   rd_fsel   ? fsel_q      : '0;

  // R16: carrier hysteresis
  wire carrier_on  = (i_carrier_level >= param_q[IDX_CON]);
  wire carrier_off = (i_carrier_level <  param_q[IDX_COFF]);
  assign carrier_d = carrier_on ? 1'b1 : (carrier_off ? 1'b0 : carrier_q);

  // R17: answer tone hysteresis
  wire answer_on  = (i_answer_level >= param_q[IDX_AON]);
  wire answer_off = (i_answer_level <  param_q[IDX_AOFF]);
  assign answer_d = answer_on ? 1'b1 : (answer_off ? 1'b0 : answer_q);

  // R3: sixteen-bit address, fourteen-bit data
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PARAMS; gi++) begin : g_param
      // R12 R13 R14 R15 R18: parameter store, defaults
      dsp_param_cell #(
        .W           (DATA_W),
        .RESET_VALUE (PARAM_RESET[gi])
      ) u_cell (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_wr      (commit && (addr_q == PARAM_ADDR[gi])),
        .i_data    (commit_data),
        .o_q       (param_q[gi])
      );
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fsel_q    <= FSEL_RESET;
      addr_q    <= '0;
      data_hi_q <= '0;
    end else if (i_ce) begin
      fsel_q    <= fsel_d;
      addr_q    <= addr_d;
      data_hi_q <= data_hi_d;
    end
  end

  // R6: DSP write strobe
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dsp_wr_q   <= 1'b0;
      coef_wr_q  <= 1'b0;
      dsp_addr_q <= '0;
      dsp_data_q <= '0;
    end else if (i_ce) begin
      dsp_wr_q  <= commit;
      coef_wr_q <= commit && addr_is_coef;
      if (commit) begin
        dsp_addr_q <= addr_q;
        dsp_data_q <= commit_data;
      end
    end
  end

  // R10: call progress control
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      squaring_q <= 1'b0;
      cascade_q  <= 1'b0;
      report_q   <= '0;
    end else if (i_ce && wr_ctrl_high) begin
      squaring_q <= i_conduit_wdata[CPC_SQUARE_BIT];
      cascade_q  <= i_conduit_wdata[CPC_CASCADE_BIT];
      report_q   <= i_conduit_wdata[REPORT_W-1:0];
    end
  end

  // R11: tone generation control
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      digit_q <= '0;
      ttype_q <= '0;
    end else if (i_ce && wr_ctrl_low) begin
      digit_q <= i_conduit_wdata[TG_DIGIT_LSB +: TG_DIGIT_W];
      ttype_q <= i_conduit_wdata[TG_TYPE_W-1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      avail_q   <= 1'b0;
      rdata_q   <= '0;
      rvalid_q  <= 1'b0;
      carrier_q <= 1'b0;
      answer_q  <= 1'b0;
    end else if (i_ce) begin
      avail_q   <= avail_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= i_conduit_rd;
      carrier_q <= carrier_d;
      answer_q  <= answer_d;
    end
  end

  assign o_conduit_rdata  = rdata_q;
  assign o_conduit_rvalid = rvalid_q;
  assign o_dsp_wr         = dsp_wr_q;
  assign o_dsp_addr       = dsp_addr_q;
  assign o_dsp_data       = dsp_data_q;
  assign o_coef_wr        = coef_wr_q;
  assign o_squaring_en    = squaring_q;
  assign o_cascade_dis    = cascade_q;
  assign o_report_en      = report_q;
  assign o_dtmf_digit     = digit_q;
  assign o_tone_type      = ttype_q;
  assign o_carrier_valid  = carrier_q;
  assign o_answer_valid   = answer_q;

  assign o_dsp_xmit_full_scale_level  = param_q[IDX_XMIT];
  assign o_dtmf_high_tone_level       = param_q[IDX_DTMFH];
  assign o_dtmf_twist_ratio           = param_q[IDX_TWIST];
  assign o_user_tone_frequency        = param_q[IDX_UFREQ];
  assign o_call_progress_detect_level = param_q[IDX_CALL_PROGRESS_DETECT_LEVEL];
  assign o_user_freq_detector_1       = param_q[IDX_UDF1];
  assign o_user_freq_detector_2       = param_q[IDX_UDF2];
  assign o_user_freq_detector_3       = param_q[IDX_UDF3];
  assign o_user_freq_detector_4       = param_q[IDX_UDF4];
  assign o_tone_generation_level      = param_q[IDX_TGEN];
  assign o_user_detector_sensitivity  = param_q[IDX_USENS];
  assign o_carrier_on_level           = param_q[IDX_CON];
  assign o_carrier_off_level          = param_q[IDX_COFF];
  assign o_answer_on_level            = param_q[IDX_AON];
  assign o_answer_off_level           = param_q[IDX_AOFF];

  // A data write with no address written first reuses the stale address, so the sequence order matters.
  sequence s_addr_low_wr;
    i_ce && wr_addr_low;
  endsequence

  sequence s_data_commit;
    i_ce && commit;
  endsequence

  property p_addr_low;
    s_addr_low_wr |=> (addr_q[BYTE_W-1:0] == $past(i_conduit_wdata));
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("address low byte not captured"); // R5

  property p_addr_high;
    i_ce && wr_addr_high |=> (addr_q[ADDR_W-1:BYTE_W] == $past(i_conduit_wdata)) &&
                             (addr_q[BYTE_W-1:0] == $past(addr_q[BYTE_W-1:0]));
  endproperty
  a_addr_high: assert property (p_addr_high) else $error("address high byte not captured"); // R5

  property p_commit;
    s_data_commit |=> o_dsp_wr && (o_dsp_addr == $past(addr_q)) &&
                      (o_dsp_data == {$past(data_hi_q), $past(i_conduit_wdata)});
  endproperty
  a_commit: assert property (p_commit) else $error("data word not committed"); // R6

  // The host leaves one idle cycle between byte writes, so the high byte is three cycles old here.
  sequence s_data_high_then_idle;
    i_ce && wr_data_high ##1 !i_conduit_wr;
  endsequence

  property p_hi_bits;
    s_data_high_then_idle ##1 s_data_commit |=>
      (o_dsp_data[DATA_W-1:BYTE_W] == $past(i_conduit_wdata[DATA_HI_W-1:0], 3));
  endproperty
  a_hi_bits: assert property (p_hi_bits) else $error("upper data bits wrong"); // R7

  property p_no_commit_other;
    i_ce && !commit |=> !o_dsp_wr;
  endproperty
  a_no_commit_other: assert property (p_no_commit_other) else $error("spurious DSP write"); // R1

  property p_status_read;
    i_ce && rd_status |=> o_conduit_rvalid && !o_conduit_rdata[STAT_RSVD_BIT] &&
      (o_conduit_rdata[TONE_TYPE_W-1:0] == $past(i_tone_type)) &&
      (o_conduit_rdata[STAT_TDET_BIT] == $past(i_tone_detected));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status byte wrong"); // R9

  property p_avail_set_wins;
    i_ce && i_dsp_data_avail |=> avail_q;
  endproperty
  a_avail_set_wins: assert property (p_avail_set_wins) else $error("available flag lost"); // R9

  property p_cpc;
    i_ce && wr_ctrl_high |=> (o_squaring_en == $past(i_conduit_wdata[CPC_SQUARE_BIT])) &&
      (o_cascade_dis == $past(i_conduit_wdata[CPC_CASCADE_BIT])) &&
      (o_report_en == $past(i_conduit_wdata[REPORT_W-1:0]));
  endproperty
  a_cpc: assert property (p_cpc) else $error("call progress control wrong"); // R10

  property p_tonegen;
    i_ce && wr_ctrl_low |=> (o_dtmf_digit == $past(i_conduit_wdata[TG_DIGIT_LSB +: TG_DIGIT_W])) &&
      (o_tone_type == $past(i_conduit_wdata[TG_TYPE_W-1:0]));
  endproperty
  a_tonegen: assert property (p_tonegen) else $error("tone generation control wrong"); // R11

  property p_param_store;
    s_data_commit ##0 (addr_q == PARAM_ADDR[IDX_XMIT]) |=>
      (o_dsp_xmit_full_scale_level == o_dsp_data);
  endproperty
  a_param_store: assert property (p_param_store) else $error("parameter not stored"); // R12

  property p_coef;
    s_data_commit ##0 addr_is_coef |=> o_coef_wr;
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient write not flagged"); // R19

  property p_carrier_on;
    i_ce && carrier_on |=> o_carrier_valid;
  endproperty
  a_carrier_on: assert property (p_carrier_on) else $error("carrier not declared valid"); // R16

  property p_answer_off;
    i_ce && answer_off && !answer_on |=> !o_answer_valid;
  endproperty
  a_answer_off: assert property (p_answer_off) else $error("answer tone not declared invalid"); // R17

  property p_addr_hold;
    i_ce && !wr_addr_low && !wr_addr_high |=> (addr_q == $past(addr_q));
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed outside address mode"); // R6

  property p_no_coef;
    i_ce && !(commit && addr_is_coef) |=> !o_coef_wr;
  endproperty
  a_no_coef: assert property (p_no_coef) else $error("spurious coefficient write"); // R19

  property p_carrier_off;
    i_ce && carrier_off && !carrier_on |=> !o_carrier_valid;
  endproperty
  a_carrier_off: assert property (p_carrier_off) else $error("carrier not declared invalid"); // R16

  property p_answer_on;
    i_ce && answer_on |=> o_answer_valid;
  endproperty
  a_answer_on: assert property (p_answer_on) else $error("answer tone not declared valid"); // R17

  // A strobe seen while the clock enable is low must leave no trace, or a frozen host could corrupt state.
  property p_ce_freeze;
    !i_ce |=> $stable(fsel_q) && $stable(addr_q) && $stable(o_report_en);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low"); // R1

endmodule

/* dsp_param_pkg.sv */
// Summary of operation
// R1: Selector picks conduit meaning per read/write.
// R2: Host writes only on-hook, command mode.
// R3: Addresses are 16 bits, data 14 bits.
// R4: Host writes address before data.
// R5: Address mode: low/high conduits take address bytes.
// R6: Data mode: conduit bytes form word for address.
// R7: High conduit gives upper six data bits.
// R8: Host writes only listed addresses, in-range values.
// R9: Status read: available, detected, reserved, tone type.
// R10: Control write: squaring, cascade disable, report enables.
// R11: Low control write: DTMF digit and tone type.
// R12: Level parameters at 0x0002 to 0x0004 with defaults.
// R13: User tone frequency at 0x0005, default 91.
// R14: Four detector centres, shared sensitivity at 0x000E.
// R15: Tone generation level at 0x000B, default 2896.
// R16: Carrier valid/invalid by on/off thresholds.
// R17: Answer tone valid/invalid by on/off thresholds.
// R18: Call progress detect level at 0x0006.
// R19: Filter coefficients 0x0010-0x0023, same indirect procedure.
// R20: Host returns selector to address mode afterwards.
package dsp_param_pkg;

  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned DATA_W     = 14;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned DATA_HI_W  = DATA_W - BYTE_W;
  localparam int unsigned NUM_PARAMS = 15;

  localparam logic [7:0] FSEL_ADDR  = 8'h00;
  localparam logic [7:0] FSEL_DATA  = 8'h01;
  localparam logic [7:0] FSEL_CTRL  = 8'h02;
  localparam logic [7:0] FSEL_RESET = FSEL_ADDR;

  typedef enum logic [1:0] {
    CONDUIT_LOW  = 2'b00,
    CONDUIT_HIGH = 2'b01,
    CONDUIT_FSEL = 2'b11
  } conduit_sel_t;

  localparam int unsigned STAT_AVAIL_BIT   = 7;
  localparam int unsigned STAT_TDET_BIT    = 6;
  localparam int unsigned STAT_RSVD_BIT    = 5;
  localparam int unsigned TONE_TYPE_W      = 5;
  localparam int unsigned CPC_SQUARE_BIT   = 7;
  localparam int unsigned CPC_CASCADE_BIT  = 6;
  localparam int unsigned REPORT_W         = 5;
  localparam int unsigned TG_DIGIT_LSB     = 3;
  localparam int unsigned TG_DIGIT_W       = 4;
  localparam int unsigned TG_TYPE_W        = 3;

  localparam int unsigned IDX_XMIT   = 0;
  localparam int unsigned IDX_DTMFH  = 1;
  localparam int unsigned IDX_TWIST  = 2;
  localparam int unsigned IDX_UFREQ  = 3;
  localparam int unsigned IDX_CALL_PROGRESS_DETECT_LEVEL   = 4;
  localparam int unsigned IDX_UDF1   = 5;
  localparam int unsigned IDX_UDF2   = 6;
  localparam int unsigned IDX_UDF3   = 7;
  localparam int unsigned IDX_UDF4   = 8;
  localparam int unsigned IDX_TGEN   = 9;
  localparam int unsigned IDX_USENS  = 10;
  localparam int unsigned IDX_CON    = 11;
  localparam int unsigned IDX_COFF   = 12;
  localparam int unsigned IDX_AON    = 13;
  localparam int unsigned IDX_AOFF   = 14;

  localparam logic [ADDR_W-1:0] PARAM_ADDR [NUM_PARAMS] = '{
    16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
    16'h0007, 16'h0008, 16'h0009, 16'h000a, 16'h000b,
    16'h000e, 16'h0024, 16'h0025, 16'h0026, 16'h0027
  };

  localparam logic [DATA_W-1:0] PARAM_RESET [NUM_PARAMS] = '{
    14'h1000, 14'h1304, 14'h0ccd, 14'h005b, 14'h1000,
    14'h137b, 14'h0218, 14'h137b, 14'h0218, 14'h0b50,
    14'h1000, 14'h0a3c, 14'h0ce4, 14'h0043, 14'h0025
  };

  localparam logic [ADDR_W-1:0] COEF_FIRST = 16'h0010;
  localparam logic [ADDR_W-1:0] COEF_LAST  = 16'h0023;

endpackage

/* dsp_param_cell.sv */
`timescale 1ns/1ps
module dsp_param_cell #(
  parameter int unsigned     W           = 14,
  parameter logic [W-1:0]    RESET_VALUE = '0
) (
  input  logic         i_clk,
  input  logic         i_sys_rst,
  input  logic         i_ce,
  input  logic         i_wr,
  input  logic [W-1:0] i_data,
  output logic [W-1:0] o_q
);

  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  assign q_d = i_wr ? i_data : q_q;
  assign o_q = q_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q_q <= RESET_VALUE;
    end else if (i_ce) begin
      q_q <= q_d;
    end
  end

endmodule

/* dsp_param_host.sv */
`timescale 1ns/1ps
module dsp_param_host
  import dsp_param_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rvalid,
  input  wire logic [BYTE_W-1:0] i_rdata,
  output logic                   o_wr,
  output logic                   o_rd,
  output logic [1:0]             o_sel,
  output logic [BYTE_W-1:0]      o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_sel = 2'b10;
    o_wdata = 8'h5a;
  end

  // Released lines show the inverse of the last value, so a late sample is caught.
  task automatic put(input logic [1:0] sel, input logic [BYTE_W-1:0] d);
    @(negedge i_clk);
    o_sel = sel;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_sel = ~sel;
    o_wdata = ~d;
  endtask

  task automatic get(input logic [1:0] sel, output logic [BYTE_W-1:0] d, output logic ok);
    int n;
    @(negedge i_clk);
    o_sel = sel;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_sel = ~sel;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_rvalid === 1'b1) begin
        ok = 1'b1;
        d = i_rdata;
      end else begin
        @(negedge i_clk);
      end
    end
  endtask

  // The bench only calls this while idle, with listed addresses and 14-bit values.
  task automatic param(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    put(2'b11, FSEL_ADDR);
    put(2'b01, a[15:8]);
    put(2'b00, a[7:0]);
    put(2'b11, FSEL_DATA);
    put(2'b01, {2'b00, v[13:8]});
    put(2'b00, v[7:0]);
    put(2'b11, FSEL_ADDR);
  endtask
endmodule

/* test_dsp_param_indirect_access.sv */
`timescale 1ns/1ps
module test_dsp_param_indirect_access
  import dsp_param_pkg::*;
;
  logic              i_clk, i_sys_rst, i_ce, wr, rd_s, rvalid, avail, tdet, dsp_wr, coef;
  logic              sq, casc, carv, ansv;
  logic [1:0]        sel;
  logic [7:0]        wdata, rdata, b, c, r;
  logic [4:0]        ttype, rep;
  logic [3:0]        dig;
  logic [2:0]        tone;
  logic [15:0]       daddr, m_addr;
  logic [13:0]       ddata, m_data, car, ans, v;
  logic [13:0]       pv [NUM_PARAMS];
  logic              m_coef, hv;
  logic [31:0]       seed;
  int unsigned       err_total, n_compared, wr_cnt, c0, i, k;
  logic [13:0]       lv [6] = '{14'h0100, 14'h0080, 14'h007f, 14'h00ff, 14'h3fff, 14'h0000};

  always #20 i_clk = ~i_clk;

  dsp_param_host u_dsp_param_host (.i_clk(i_clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr),
    .o_rd(rd_s), .o_sel(sel), .o_wdata(wdata));

  dsp_param_indirect_access u_dsp_param_indirect_access (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_conduit_wr(wr), .i_conduit_rd(rd_s), .i_conduit_sel(sel), .i_conduit_wdata(wdata),
    .i_dsp_data_avail(avail), .i_tone_detected(tdet), .i_tone_type(ttype), .i_carrier_level(car),
    .i_answer_level(ans), .o_conduit_rdata(rdata), .o_conduit_rvalid(rvalid), .o_dsp_wr(dsp_wr),
    .o_dsp_addr(daddr), .o_dsp_data(ddata), .o_coef_wr(coef), .o_squaring_en(sq), .o_cascade_dis(casc),
    .o_report_en(rep), .o_dtmf_digit(dig), .o_tone_type(tone), .o_carrier_valid(carv),
    .o_answer_valid(ansv), .o_dsp_xmit_full_scale_level(pv[0]), .o_dtmf_high_tone_level(pv[1]),
    .o_dtmf_twist_ratio(pv[2]), .o_user_tone_frequency(pv[3]), .o_call_progress_detect_level(pv[4]),
    .o_user_freq_detector_1(pv[5]), .o_user_freq_detector_2(pv[6]), .o_user_freq_detector_3(pv[7]),
    .o_user_freq_detector_4(pv[8]), .o_tone_generation_level(pv[9]), .o_user_detector_sensitivity(pv[10]),
    .o_carrier_on_level(pv[11]), .o_carrier_off_level(pv[12]), .o_answer_on_level(pv[13]),
    .o_answer_off_level(pv[14]));

  // Latency of the commit pulse is not assumed; each pulse is counted and captured.
  always @(negedge i_clk) begin
    if (dsp_wr === 1'b1) begin
      wr_cnt++;
      m_addr = daddr;
      m_data = ddata;
      m_coef = coef;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic hyst(input logic [13:0] lvl, input logic [13:0] on, input logic [13:0] off,
                                input logic prev);
    return (lvl >= on) ? 1'b1 : ((lvl < off) ? 1'b0 : prev);
  endfunction

  task automatic summarize();
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    logic ok;
    u_dsp_param_host.get(s, d, ok);
    check("read answer", ok, 1'b1);
    if (ok !== 1'b1) begin
      summarize();
    end
  endtask

  task automatic wr_param(input logic [15:0] a, input logic [13:0] val, input logic cf);
    c0 = wr_cnt;
    u_dsp_param_host.param(a, val);
    check("commit count", wr_cnt - c0, 1);
    check("dsp address", m_addr, a);
    check("dsp data", m_data, val);
    check("coef strobe", m_coef, cf);
  endtask

  initial begin
    #800000;
    check("watchdog", 0, 1);
    summarize();
  end

  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    avail = 1'b0;
    tdet = 1'b0;
    ttype = 5'h00;
    car = 14'h0000;
    ans = 14'h0000;
    seed = 32'h4a92;
    wr_cnt = 0;
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    for (i = 0; i < NUM_PARAMS; i++) check("param default", pv[i], PARAM_RESET[i]);
    for (i = 0; i < NUM_PARAMS; i++) begin
      v = 14'(rnd());
      wr_param(PARAM_ADDR[i], v, 1'b0);
      check("param value", pv[i], v);
    end
    wr_param(16'h0015, 14'h0135, 1'b1);
    wr_param(COEF_FIRST, 14'h3fff, 1'b1);
    wr_param(COEF_LAST, 14'h0000, 1'b1);
    c0 = wr_cnt;
    u_dsp_param_host.put(2'b11, FSEL_CTRL);
    for (k = 0; k < 8; k++) begin
      b = (k == 0) ? 8'hff : 8'(rnd());
      c = {1'b0, 4'(rnd()), k[2:0]};
      u_dsp_param_host.put(2'b01, b);
      u_dsp_param_host.put(2'b00, c);
      check("squaring", sq, b[7]);
      check("cascade off", casc, b[6]);
      check("report enables", rep, b[4:0]);
      check("dtmf digit", dig, c[6:3]);
      check("tone type", tone, c[2:0]);
    end
    check("no commit in control mode", wr_cnt - c0, 0);
    tdet = 1'b1;
    ttype = 5'(rnd());
    avail = 1'b1;
    rd(2'b00, r);
    check("status", r, {2'b11, 1'b0, ttype});
    avail = 1'b0;
    tdet = 1'b0;
    rd(2'b00, r);
    check("status set wins", r, {3'b100, ttype});
    rd(2'b00, r);
    check("status cleared", r, {3'b000, ttype});
    rd(2'b11, r);
    check("selector", r, FSEL_CTRL);
    rd(2'b01, r);
    check("high conduit read", r, 8'h00);
    u_dsp_param_host.put(2'b10, 8'h01);
    u_dsp_param_host.put(2'b11, 8'h03);
    u_dsp_param_host.put(2'b00, 8'h55);
    check("odd selector ignored", wr_cnt - c0, 0);
    rd(2'b11, r);
    check("selector odd", r, 8'h03);
    i_ce = 1'b0;
    u_dsp_param_host.put(2'b11, FSEL_ADDR);
    i_ce = 1'b1;
    rd(2'b11, r);
    check("selector frozen", r, 8'h03);
    wr_param(16'h0024, 14'h0100, 1'b0);
    wr_param(16'h0025, 14'h0080, 1'b0);
    wr_param(16'h0026, 14'h0100, 1'b0);
    wr_param(16'h0027, 14'h0080, 1'b0);
    hv = 1'b0;
    for (k = 0; k < 6; k++) begin
      car = lv[k];
      ans = lv[k];
      hv = hyst(lv[k], 14'h0100, 14'h0080, hv);
      repeat (2) @(negedge i_clk);
      check("carrier valid", carv, hv);
      check("answer valid", ansv, hv);
    end
    car = 14'h3fff;
    u_dsp_param_host.put(2'b11, FSEL_CTRL);
    check("carrier before reset", carv, 1'b1);
    i_sys_rst = 1'b1;
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    check("default after reset", pv[11], PARAM_RESET[11]);
    check("carrier after reset", carv, 1'b0);
    check("squaring after reset", sq, 1'b0);
    rd(2'b11, r);
    check("selector after reset", r, FSEL_RESET);
    summarize();
  end
endmodule
